/* verilog/twm_pkg.sv */
package twm_pkg;
	// Clock period and one third of the bit period in a byte slot.
	localparam int TWM_CLK_NS      = 10;
	localparam int TWM_QUARTER_NS  = 2500;
	localparam int TWM_QUARTER_CYC =
		(TWM_QUARTER_NS + TWM_CLK_NS - 1) / TWM_CLK_NS;
	// Register byte offsets.
	localparam logic [7:0] TWM_OFF_CTRL = 8'h00;
	localparam logic [7:0] TWM_OFF_STAT = 8'h04;
	localparam logic [7:0] TWM_OFF_DATA = 8'h08;
	// Control register bit positions.
	localparam int TWM_CB_FLAG = 7;
	localparam int TWM_CB_ACK  = 6;
	localparam int TWM_CB_STA  = 5;
	localparam int TWM_CB_STO  = 4;
	localparam int TWM_CB_WCOL = 3;
	localparam int TWM_CB_EN   = 2;
	localparam int TWM_CB_IE   = 0;
	// Reset values.
	localparam logic [7:0] TWM_DATA_RST  = 8'hff;
	localparam logic [1:0] TWM_PRESC_RST = 2'h0;
	// Status codes with the prescaler bits at zero.
	localparam logic [7:0] TWM_SC_START  = 8'h08;
	localparam logic [7:0] TWM_SC_RSTART = 8'h10;
	localparam logic [7:0] TWM_SC_WA_ACK = 8'h18;
	localparam logic [7:0] TWM_SC_WA_NAK = 8'h20;
	localparam logic [7:0] TWM_SC_D_ACK  = 8'h28;
	localparam logic [7:0] TWM_SC_D_NAK  = 8'h30;
	localparam logic [7:0] TWM_SC_LOST   = 8'h38;
	localparam logic [7:0] TWM_SC_RA_ACK = 8'h40;
	localparam logic [7:0] TWM_SC_RA_NAK = 8'h48;
	localparam logic [7:0] TWM_SC_IDLE   = 8'hf8;
	// Commands from the step sequencer to the bit engine.
	typedef enum logic [1:0] {
		TWM_CMD_START = 2'b00,
		TWM_CMD_BYTE  = 2'b01,
		TWM_CMD_STOP  = 2'b10
	} twm_cmd_t;
endpackage

/* verilog/twm_bit_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Link between the step sequencer and the bit engine.
interface twm_bit_if;
	import twm_pkg::*;
	logic     cmd_valid;
	twm_cmd_t cmd;
	logic     [7:0] tx_byte;
	logic     done;
	logic     ack_n;
	logic     lost;
	logic     own;
	modport ctl(output cmd_valid, cmd, tx_byte, input done, ack_n, lost, own);
	modport eng(input cmd_valid, cmd, tx_byte, output done, ack_n, lost, own);
endinterface
`default_nettype wire

/* verilog/twm_bit_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module twm_bit_engine #(
	parameter int QUARTER = twm_pkg::TWM_QUARTER_CYC
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	twm_bit_if.eng    bi,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      scl_oe_n,
	output logic      sda_out,
	output logic      sda_oe_n
);
	import twm_pkg::*;
	localparam int CW = $clog2(QUARTER + 1);
	typedef enum logic [1:0] {
		E_IDLE  = 2'b00,
		E_START = 2'b01,
		E_BIT   = 2'b10,
		E_STOP  = 2'b11
	} twm_eng_t;
	twm_eng_t        st_q;
	logic [1:0]      ph_q;
	logic [3:0]      bit_q;
	logic [8:0]      sh_q;
	logic [CW-1:0]   cnt_q;
	logic            scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q;
	logic            busy_q, own_q, done_q, lost_q, ack_q;
	logic            stall, tick;

	if (QUARTER < 2) begin : g_chk
		$error("QUARTER must be at least 2");
	end

	// Two-stage synchronisers for the bus lines, plus one history stage.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			{scl_m_q, scl_s_q, sda_m_q, sda_s_q, sda_p_q} <= 5'h1f;
		end else begin
			{scl_m_q, scl_s_q} <= {scl_in, scl_m_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {sda_in, sda_m_q, sda_s_q};
		end
	end

	// Bus busy between any START and the next STOP, whoever sent them.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
		end else if (scl_s_q && sda_p_q && !sda_s_q) begin
			busy_q <= 1'b1;
		end else if (scl_s_q && !sda_p_q && sda_s_q) begin
			busy_q <= 1'b0;
		end
	end

	// A released clock held low by a slave or a START on a busy bus not owned by this master waits.
	assign stall = (st_q != E_IDLE && scl_oe_n && !scl_s_q) ||
		(st_q == E_START && ph_q == 2'd0 && !own_q && busy_q);
	assign tick = (cnt_q == '0) && !stall;

	// Quarter period timer.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else if (st_q == E_IDLE || stall || tick) begin
			cnt_q <= CW'(QUARTER - 1);
		end else begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// Open-drain pins only ever pull low.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			scl_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end

	// Line sequencer for START, STOP and nine-bit byte slots.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= E_IDLE;
			ph_q <= 2'd0;
			bit_q <= 4'd0;
			sh_q <= 9'h1ff;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			own_q <= 1'b0;
			done_q <= 1'b0;
			lost_q <= 1'b0;
			ack_q <= 1'b1;
		end else begin
			done_q <= 1'b0;
			case (st_q)
				E_IDLE: begin
					ph_q <= 2'd0;
					bit_q <= 4'd0;
					if (bi.cmd_valid) begin
						lost_q <= 1'b0;
						case (bi.cmd)
							TWM_CMD_START: begin
								st_q <= E_START;
								sda_oe_n <= 1'b1;
							end
							TWM_CMD_BYTE: begin
								st_q <= E_BIT;
								sh_q <= {bi.tx_byte, 1'b1};
								sda_oe_n <= bi.tx_byte[7];
							end
							default: begin
								st_q <= E_STOP;
								sda_oe_n <= 1'b0;
							end
						endcase
					end
				end
				E_START: begin
					if (tick) begin
						ph_q <= ph_q + 2'd1;
						case (ph_q)
							2'd0: scl_oe_n <= 1'b1;
							2'd1: sda_oe_n <= 1'b0;
							2'd2: scl_oe_n <= 1'b0;
							default: begin
								own_q <= 1'b1;
								done_q <= 1'b1;
								st_q <= E_IDLE;
							end
						endcase
					end
				end
				E_BIT: begin
					if (tick) begin
						case (ph_q)
							2'd0: begin
								scl_oe_n <= 1'b0 ^ 1'b1;
								ph_q <= 2'd1;
							end
							2'd1: begin
								ack_q <= sda_s_q;
								ph_q <= 2'd2;
								if (sda_oe_n && !sda_s_q && bit_q != 4'd8) begin
									scl_oe_n <= 1'b1;
									own_q <= 1'b0;
									lost_q <= 1'b1;
									done_q <= 1'b1;
									st_q <= E_IDLE;
								end
							end
							default: begin
								scl_oe_n <= 1'b0;
								ph_q <= 2'd0;
								if (bit_q == 4'd8) begin
									done_q <= 1'b1;
									st_q <= E_IDLE;
								end else begin
									bit_q <= bit_q + 4'd1;
									sda_oe_n <= sh_q[7];
									sh_q <= {sh_q[7:0], 1'b1};
								end
							end
						endcase
					end
				end
				default: begin
					if (tick) begin
						ph_q <= ph_q + 2'd1;
						case (ph_q)
							2'd0: scl_oe_n <= 1'b1;
							2'd1: sda_oe_n <= 1'b1;
							default: begin
								own_q <= 1'b0;
								done_q <= 1'b1;
								st_q <= E_IDLE;
							end
						endcase
					end
				end
			endcase
		end
	end

	assign bi.done  = done_q;
	assign bi.ack_n = ack_q;
	assign bi.lost  = lost_q;
	assign bi.own   = own_q;
endmodule
`default_nettype wire

/* verilog/twm_master_tx.sv */
// Summary of operation
// - After a START request the unit sends START once the bus is free.
// - START sent sets the step flag with status 0x08.
// - Writing one to the step flag clears it and lets the step go on.
// - Direction bit of each address sent picks transmit or receive mode.
// - Address with write sent and ack sampled: flag with 0x18, 0x20 or 0x38.
// - Data writes while the flag is low are dropped and set collision flag.
// - Repeated START reports 0x10 and the master keeps the bus.
// - At 0x08 a flag clear sends the loaded address and samples ack.
// - At 0x10 the loaded address goes out; read direction selects receive.
// - At 0x18 or 0x20 a plain flag clear sends the loaded data byte.
// - A sent data byte reports 0x28 on ack and 0x30 on no ack.
// - Flag clear with stop only sends STOP and clears the stop request.
// - Flag clear with start and stop sends STOP, then START, clears stop.
// - Lost arbitration reports 0x38; then release, or START when bus frees.
// - While the step flag is set the transfer stays suspended.
`timescale 1ns/1ps
`default_nettype none
module twm_master_tx #(
	parameter int QUARTER = twm_pkg::TWM_QUARTER_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq_req,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe_n,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n
);
	import twm_pkg::*;

	typedef enum logic [2:0] {
		M_IDLE       = 3'b000,
		M_START      = 3'b001,
		M_ADDR       = 3'b010,
		M_DATA       = 3'b011,
		M_STOP       = 3'b100,
		M_STOP_START = 3'b101,
		M_HOLD       = 3'b110
	} twm_mst_t;

	twm_mst_t    st_q;
	twm_cmd_t    cmd_q;
	logic        cmd_valid_q;
	logic        rep_q;
	logic        mode_rx_q;
	logic        flag_q, ack_en_q, sta_q, sto_q, wcol_q, en_q, ie_q;
	logic [1:0]  presc_q;
	logic [7:0]  code_q, code_d;
	logic [7:0]  data_q;
	logic [7:0]  ctrl_rd;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q, irq_q;
	logic        acc, wr, wr_ctrl, wr_stat, wr_data;
	logic        step_set, addr_ok;

	twm_bit_if bi();

	// Bit engine that owns the bus pins.
	twm_bit_engine #(
		.QUARTER(QUARTER)
	) u_eng (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.bi      (bi),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.scl_out (scl_out),
		.scl_oe_n(scl_oe_n),
		.sda_out (sda_out),
		.sda_oe_n(sda_oe_n)
	);

	assign bi.cmd_valid = cmd_valid_q;
	assign bi.cmd       = cmd_q;
	assign bi.tx_byte   = data_q;

	// Bus decode: one wait state, writes land on the completing edge.
	assign acc     = psel && penable && !pready_q;
	assign wr      = psel && penable && pready_q && pwrite;
	assign addr_ok = paddr == TWM_OFF_CTRL || paddr == TWM_OFF_STAT ||
		paddr == TWM_OFF_DATA;
	assign wr_ctrl = wr && paddr == TWM_OFF_CTRL;
	assign wr_stat = wr && paddr == TWM_OFF_STAT;
	assign wr_data = wr && paddr == TWM_OFF_DATA;

	// Control register image as software reads it.
	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[TWM_CB_FLAG] = flag_q;
		ctrl_rd[TWM_CB_ACK]  = ack_en_q;
		ctrl_rd[TWM_CB_STA]  = sta_q;
		ctrl_rd[TWM_CB_STO]  = sto_q;
		ctrl_rd[TWM_CB_WCOL] = wcol_q;
		ctrl_rd[TWM_CB_EN]   = en_q;
		ctrl_rd[TWM_CB_IE]   = ie_q;
	end

	// Bus answer: ready, error and read data all come from flip-flops.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= acc;
			pslverr_q <= acc && !addr_ok;
			prdata_q <= 32'h0000_0000;
			if (acc && !pwrite) begin
				case (paddr)
					TWM_OFF_CTRL: prdata_q <= {24'h00_0000, ctrl_rd};
					TWM_OFF_STAT: prdata_q <= {24'h00_0000, code_q[7:3],
						1'b0, presc_q};
					TWM_OFF_DATA: prdata_q <= {24'h00_0000, data_q};
					default:      prdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// Software-owned control bits; stop also self-clears after STOP.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_en_q <= 1'b0;
			sta_q <= 1'b0;
			en_q <= 1'b0;
			ie_q <= 1'b0;
		end else if (wr_ctrl) begin
			ack_en_q <= pwdata[TWM_CB_ACK];
			sta_q <= pwdata[TWM_CB_STA];
			en_q <= pwdata[TWM_CB_EN];
			ie_q <= pwdata[TWM_CB_IE];
		end
	end

	// Stop request clears itself once the STOP is on the bus.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sto_q <= 1'b0;
		end else if ((st_q == M_STOP || st_q == M_STOP_START) && bi.done) begin
			sto_q <= 1'b0;
		end else if (wr_ctrl) begin
			sto_q <= pwdata[TWM_CB_STO];
		end
	end

	// Step flag: hardware set wins over a software clear.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			flag_q <= 1'b0;
		end else if (step_set) begin
			flag_q <= 1'b1;
		end else if (wr_ctrl && pwdata[TWM_CB_FLAG]) begin
			flag_q <= 1'b0;
		end
	end

	// Data register and write collision flag.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_q <= TWM_DATA_RST;
			wcol_q <= 1'b0;
		end else if (wr_data) begin
			if (flag_q) begin
				data_q <= pwdata[7:0];
				wcol_q <= 1'b0;
			end else begin
				wcol_q <= 1'b1;
			end
		end
	end

	// Prescaler bits are stored and read back only.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			presc_q <= TWM_PRESC_RST;
		end else if (wr_stat) begin
			presc_q <= pwdata[1:0];
		end
	end

	// Interrupt request follows the step flag when enabled.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_q && ie_q;
		end
	end

	assign irq_req = irq_q;

	// Status code that each finished step reports.
	always_comb begin
		step_set = 1'b0;
		code_d = code_q;
		case (st_q)
			M_START: begin
				if (bi.done) begin
					step_set = 1'b1;
					code_d = rep_q ? TWM_SC_RSTART : TWM_SC_START;
				end
			end
			M_ADDR: begin
				if (bi.done) begin
					step_set = 1'b1;
					if (bi.lost) begin
						code_d = TWM_SC_LOST;
					end else if (data_q[0]) begin
						code_d = bi.ack_n ? TWM_SC_RA_NAK : TWM_SC_RA_ACK;
					end else begin
						code_d = bi.ack_n ? TWM_SC_WA_NAK : TWM_SC_WA_ACK;
					end
				end
			end
			M_DATA: begin
				if (bi.done) begin
					step_set = 1'b1;
					if (bi.lost) begin
						code_d = TWM_SC_LOST;
					end else begin
						code_d = bi.ack_n ? TWM_SC_D_NAK : TWM_SC_D_ACK;
					end
				end
			end
			M_STOP: begin
				if (bi.done) begin
					code_d = TWM_SC_IDLE;
				end
			end
			default: begin
				step_set = 1'b0;
			end
		endcase
	end

	// Step sequencer: issues one bus step per flag clear.
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= M_IDLE;
			cmd_q <= TWM_CMD_START;
			cmd_valid_q <= 1'b0;
			rep_q <= 1'b0;
			mode_rx_q <= 1'b0;
			code_q <= TWM_SC_IDLE;
		end else begin
			cmd_valid_q <= 1'b0;
			code_q <= code_d;
			case (st_q)
				M_IDLE: begin
					if (en_q && sta_q && !flag_q) begin
						cmd_valid_q <= 1'b1;
						cmd_q <= TWM_CMD_START;
						rep_q <= bi.own;
						st_q <= M_START;
					end
				end
				M_START, M_ADDR, M_DATA: begin
					if (bi.done) begin
						st_q <= M_HOLD;
					end
				end
				M_STOP: begin
					if (bi.done) begin
						st_q <= M_IDLE;
					end
				end
				M_STOP_START: begin
					if (bi.done) begin
						cmd_valid_q <= 1'b1;
						cmd_q <= TWM_CMD_START;
						rep_q <= 1'b0;
						st_q <= M_START;
					end
				end
				default: begin
					if (!flag_q && en_q) begin
						if (code_q == TWM_SC_LOST || code_q == TWM_SC_IDLE) begin
							if (sta_q) begin
								cmd_valid_q <= 1'b1;
								cmd_q <= TWM_CMD_START;
								rep_q <= bi.own;
								st_q <= M_START;
							end else begin
								code_q <= TWM_SC_IDLE;
								st_q <= M_IDLE;
							end
						end else if (code_q == TWM_SC_START ||
							code_q == TWM_SC_RSTART) begin
							cmd_valid_q <= 1'b1;
							cmd_q <= TWM_CMD_BYTE;
							mode_rx_q <= data_q[0];
							st_q <= M_ADDR;
						end else if (sta_q && sto_q) begin
							cmd_valid_q <= 1'b1;
							cmd_q <= TWM_CMD_STOP;
							st_q <= M_STOP_START;
						end else if (sto_q) begin
							cmd_valid_q <= 1'b1;
							cmd_q <= TWM_CMD_STOP;
							st_q <= M_STOP;
						end else if (sta_q) begin
							cmd_valid_q <= 1'b1;
							cmd_q <= TWM_CMD_START;
							rep_q <= bi.own;
							st_q <= M_START;
						end else begin
							cmd_valid_q <= 1'b1;
							cmd_q <= TWM_CMD_BYTE;
							st_q <= M_DATA;
						end
					end
				end
			endcase
		end
	end

	// Checks on the sequencer and the register file.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_start_issue: assert property (
		st_q == M_IDLE && en_q && sta_q && !flag_q
		|=> cmd_valid_q && cmd_q == TWM_CMD_START && st_q == M_START)
		else $error("START request not issued");

	a_start_code: assert property (
		st_q == M_START && bi.done && !rep_q
		|=> flag_q && code_q == TWM_SC_START)
		else $error("START did not report 0x08");

	a_rstart_code: assert property (
		st_q == M_START && bi.done && rep_q
		|=> flag_q && code_q == TWM_SC_RSTART)
		else $error("Repeated START did not report 0x10");

	a_flag_clear: assert property (
		wr_ctrl && pwdata[TWM_CB_FLAG] && !step_set |=> !flag_q)
		else $error("Flag not cleared by write of one");

	a_addr_send: assert property (
		st_q == M_HOLD && !flag_q && en_q && code_q == TWM_SC_START
		|=> cmd_valid_q && cmd_q == TWM_CMD_BYTE && st_q == M_ADDR
		&& bi.tx_byte == $past(data_q))
		else $error("Address not sent after 0x08");

	a_mode_pick: assert property (
		st_q == M_HOLD && !flag_q && en_q && code_q == TWM_SC_RSTART
		|=> st_q == M_ADDR && mode_rx_q == $past(data_q[0]))
		else $error("Mode not taken from direction bit");

	a_addr_code: assert property (
		st_q == M_ADDR && bi.done && !bi.lost && !data_q[0]
		|=> flag_q && code_q == ($past(bi.ack_n) ? TWM_SC_WA_NAK
		: TWM_SC_WA_ACK))
		else $error("Wrong code after address with write");

	a_data_send: assert property (
		st_q == M_HOLD && !flag_q && en_q && !sta_q && !sto_q &&
		(code_q == TWM_SC_WA_ACK || code_q == TWM_SC_WA_NAK)
		|=> cmd_valid_q && cmd_q == TWM_CMD_BYTE && st_q == M_DATA)
		else $error("Data byte not sent after address");

	a_data_code: assert property (
		st_q == M_DATA && bi.done && !bi.lost
		|=> flag_q && code_q == ($past(bi.ack_n) ? TWM_SC_D_NAK
		: TWM_SC_D_ACK))
		else $error("Wrong code after data byte");

	a_wcol_set: assert property (
		wr_data && !flag_q |=> wcol_q && data_q == $past(data_q))
		else $error("Collision write not dropped");

	a_stop_clear: assert property (
		st_q == M_STOP && bi.done && !wr_ctrl
		|=> !sto_q && st_q == M_IDLE && code_q == TWM_SC_IDLE)
		else $error("STOP did not clear stop request");

	a_stop_start: assert property (
		st_q == M_STOP_START && bi.done
		|=> cmd_valid_q && cmd_q == TWM_CMD_START && !sto_q)
		else $error("STOP then START not issued");

	a_lost_code: assert property (
		(st_q == M_ADDR || st_q == M_DATA) && bi.done && bi.lost
		|=> flag_q && code_q == TWM_SC_LOST)
		else $error("Lost arbitration not reported");

	a_hold_still: assert property (
		flag_q [*2] |-> !cmd_valid_q && $stable(st_q))
		else $error("Transfer advanced while flag set");

	a_irq_follow: assert property (
		(flag_q && ie_q) [*2] |-> irq_q ##1 (irq_q || !flag_q))
		else $error("Interrupt request does not follow flag");

	c_start: cover property (st_q == M_START && bi.done);
	c_data_ack: cover property (st_q == M_DATA && bi.done && !bi.ack_n);
	c_lost: cover property (bi.done && bi.lost);
	c_stop_start: cover property (st_q == M_STOP_START && bi.done);
endmodule
`default_nettype wire

/* verif/twm_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Slave receiver on the two-wire bus; a high pull output pulls a line low.
module twm_slave_model (
	input  wire logic  scl,
	input  wire logic  sda,
	input  wire logic  nack,
	input  wire logic  grab,
	input  wire logic  slow,
	output logic       scl_low,
	output logic       sda_low,
	output logic [7:0] got,
	output int         nbytes
);
	int         bits = 0;
	logic [7:0] sh   = 8'h00;
	logic       ack  = 1'b0;
	initial begin
		scl_low = 1'b0;
		got = 8'h00;
		nbytes = 0;
	end
	// A rival master holds data low in bit slots so the block loses.
	assign sda_low = ack | (grab & (bits < 8));
	// A start or stop condition restarts the bit count.
	always @(sda) begin
		if (scl === 1'b1) begin
			bits = 0;
		end
	end
	// Bits are taken on the clock rise, most significant first.
	always @(posedge scl) begin
		if (bits < 8) begin
			sh = {sh[6:0], sda};
		end
		bits++;
		if (bits == 8) begin
			got = sh;
			nbytes++;
		end
	end
	// Ack is held through the ninth bit; a slow slave stretches the clock.
	always @(negedge scl) begin
		ack = (bits == 8) && !nack;
		if (bits >= 9) begin
			bits = 0;
		end
		if (slow) begin
			scl_low = 1'b1;
			#300;
			scl_low = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* verif/two_wire_master_transmit_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module two_wire_master_transmit_bench;
	import twm_pkg::*;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq_req;
	logic        scl_oe_n;
	logic        sda_oe_n;
	logic        scl_out;
	logic        sda_out;
	logic        nack = 1'b0;
	logic        grab = 1'b0;
	logic        slow = 1'b0;
	logic        scl_low;
	logic        sda_low;
	logic [7:0]  got;
	int          nbytes;
	logic [31:0] rd;
	logic        er;
	int          err_count = 0;
	int          tests_run = 0;
	wire         scl = ~(~scl_oe_n | scl_low);
	wire         sda = ~(~sda_oe_n | sda_low);
	always #5 ref_clk = ~ref_clk;
	twm_master_tx #(.QUARTER(4)) i_twm_master_tx (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq_req(irq_req), .scl_in(scl),
		.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n));
	twm_slave_model i_twm_slave_model (.scl(scl), .sda(sda), .nack(nack),
		.grab(grab), .slow(slow), .scl_low(scl_low), .sda_low(sda_low),
		.got(got), .nbytes(nbytes));
	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// One APB transfer, entered just after a clock edge.
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
		if (n >= 20) begin
			err_count++;
			close_out();
		end
	endtask
	// Writes control, waits for the step flag and checks the masked code.
	task automatic step(input logic [7:0] c, input logic [7:0] code);
		int n;
		bus(1'b1, TWM_OFF_CTRL, c);
		n = 0;
		do begin
			bus(1'b0, TWM_OFF_CTRL, 8'h00);
			n++;
		end while (rd[7] !== 1'b1 && n < 400);
		if (n >= 400) begin
			err_count++;
			close_out();
		end
		bus(1'b0, TWM_OFF_STAT, 8'h00);
		`CHK(rd[7:0] & 8'hf8, code)
	endtask
	// Sends STOP and waits until the stop request clears itself.
	task automatic stop_wait;
		int n;
		bus(1'b1, TWM_OFF_CTRL, 8'h94);
		n = 0;
		do begin
			bus(1'b0, TWM_OFF_CTRL, 8'h00);
			n++;
		end while (rd[4] !== 1'b0 && n < 400);
		if (n >= 400) begin
			err_count++;
			close_out();
		end
		`CHK(rd[7:4], 4'h0)
		bus(1'b0, TWM_OFF_STAT, 8'h00);
		`CHK(rd[7:0] & 8'hf8, TWM_SC_IDLE)
		`CHK({scl, sda}, 2'b11)
	endtask
	// Reset values, unmapped access and a data write out of turn.
	task automatic t_regs;
		bus(1'b0, TWM_OFF_CTRL, 8'h00);
		`CHK(rd, 32'h0)
		bus(1'b0, TWM_OFF_STAT, 8'h00);
		`CHK(rd, 32'hf8)
		bus(1'b0, 8'h0c, 8'h00);
		`CHK({er, rd}, {1'b1, 32'h0})
		bus(1'b1, TWM_OFF_DATA, 8'h5a);
		bus(1'b0, TWM_OFF_CTRL, 8'h00);
		`CHK(rd[3], 1'b1)
		bus(1'b0, TWM_OFF_DATA, 8'h00);
		`CHK(rd[7:0], TWM_DATA_RST)
	endtask
	// Address, data, repeated START, read address, STOP then START.
	task automatic t_send;
		int k;
		step(8'ha5, TWM_SC_START);
		`CHK(irq_req, 1'b1)
		bus(1'b1, TWM_OFF_DATA, 8'ha4);
		bus(1'b0, TWM_OFF_CTRL, 8'h00);
		`CHK(rd[3], 1'b0)
		step(8'h84, TWM_SC_WA_ACK);
		`CHK(got, 8'ha4)
		k = nbytes;
		repeat (100) @(posedge ref_clk);
		`CHK({scl, nbytes}, {1'b0, k})
		bus(1'b1, TWM_OFF_DATA, 8'h3c);
		step(8'h84, TWM_SC_D_ACK);
		`CHK(got, 8'h3c)
		step(8'ha4, TWM_SC_RSTART);
		bus(1'b1, TWM_OFF_DATA, 8'ha5);
		step(8'h84, TWM_SC_RA_ACK);
		nack <= 1'b1;
		bus(1'b1, TWM_OFF_DATA, 8'h11);
		step(8'h84, TWM_SC_D_NAK);
		step(8'hb4, TWM_SC_START);
		bus(1'b0, TWM_OFF_CTRL, 8'h00);
		`CHK(rd[4], 1'b0)
		bus(1'b1, TWM_OFF_DATA, 8'ha4);
		step(8'h84, TWM_SC_WA_NAK);
		stop_wait();
		nack <= 1'b0;
	endtask
	// A rival master wins; then START again once the bus is free.
	task automatic t_lost;
		slow <= 1'b1;
		step(8'ha4, TWM_SC_START);
		`CHK(irq_req, 1'b0)
		bus(1'b1, TWM_OFF_DATA, 8'hff);
		grab <= 1'b1;
		step(8'h84, TWM_SC_LOST);
		`CHK({scl_oe_n, sda_oe_n, scl_out, sda_out}, 4'hc)
		grab <= 1'b0;
		step(8'ha4, TWM_SC_START);
		// A START is answered by an address before STOP may follow.
		bus(1'b1, TWM_OFF_DATA, 8'ha4);
		step(8'h84, TWM_SC_WA_ACK);
		slow <= 1'b0;
		stop_wait();
	endtask
	// Main sequence.
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_regs();
		t_send();
		t_lost();
		close_out();
	end
endmodule
`default_nettype wire
